// [cmp_pkg.sv]
// shared constants of the comparator output control block
package cmp_pkg;

    // largest bank the address map can hold
    localparam int unsigned MAX_CMP          = 8;

    // byte offsets on the register bus
    localparam logic [7:0]  CTRL_FIRST_BASE  = 8'h00;
    localparam logic [7:0]  CTRL_SECOND_BASE = 8'h04;
    localparam logic [7:0]  CHAN_STRIDE      = 8'h08;
    localparam logic [7:0]  ALL_RESULTS_OFF  = 8'h40;
    localparam logic [7:0]  IRQ_STATUS_OFF   = 8'h44;
    localparam logic [7:0]  IRQ_MASK_OFF     = 8'h48;

    // compare_ctrl_first field positions
    localparam int unsigned CF_ON_BIT        = 7;
    localparam int unsigned CF_OUT_BIT       = 6;
    localparam int unsigned CF_INV_BIT       = 4;
    localparam int unsigned CF_SEP_BIT       = 1;
    localparam int unsigned CF_SYNC_BIT      = 0;

    // compare_ctrl_second field positions
    localparam int unsigned CS_RISE_BIT      = 7;
    localparam int unsigned CS_FALL_BIT      = 6;

    // reset values of the control fields
    localparam logic        ON_RESET         = 1'b0;
    localparam logic        INV_RESET        = 1'b0;
    localparam logic        SEP_RESET        = 1'b0;
    localparam logic        SYNC_RESET       = 1'b0;
    localparam logic        RISE_RESET       = 1'b0;
    localparam logic        FALL_RESET       = 1'b0;
    localparam logic        MASK_RESET       = 1'b0;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

endpackage

// [cmp_sync2.sv]
// two-stage synchroniser for asynchronous levels
`timescale 1ns/1ns
`default_nettype none

module cmp_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,    // instruction clock
    input  wire logic         reset_n, // async reset, active low
    input  wire logic [W-1:0] din,     // asynchronous levels
    output var  logic [W-1:0] dout     // levels on mclk
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cmp_sync_state_t;

    cmp_sync_state_t st_q;
    cmp_sync_state_t st_d;

    generate
        if (W < 1) begin : g_chk
            $error("cmp_sync2: width must be at least one");
        end
    endgenerate

    // s1 is read only by s2
    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;

endmodule // cmp_sync2

`default_nettype wire

// [cmp_edge_flag.sv]
// edge detectors and sticky event flags, one per comparator
`timescale 1ns/1ns
`default_nettype none

module cmp_edge_flag #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,     // instruction clock
    input  wire logic         reset_n,  // async reset, active low
    input  wire logic [W-1:0] level,    // reported results
    input  wire logic [W-1:0] rise_en,  // rise_irq_enable per channel
    input  wire logic [W-1:0] fall_en,  // fall_irq_enable per channel
    input  wire logic [W-1:0] clear,    // write-one-to-clear pulses
    output var  logic [W-1:0] flag      // edge_event_flag per channel
);

    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] flag;
    } cmp_edge_state_t;

    cmp_edge_state_t st_q;
    cmp_edge_state_t st_d;
    logic [W-1:0]    set_ev;

    always_comb begin
        set_ev  = (level & ~st_q.prev & rise_en)
                | (~level & st_q.prev & fall_en);
        st_d      = st_q;
        st_d.prev = level;
        // a new edge beats a clear in the same cycle
        st_d.flag = (st_q.flag & ~clear) | set_ev;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag = st_q.flag;

endmodule // cmp_edge_flag

`default_nettype wire

// [cmp_output_ctrl.sv]
// comparator bank control, result path and register slave
`timescale 1ns/1ns
`default_nettype none

module cmp_output_ctrl #(
    parameter int unsigned N_CMP = 8
) (
    input  wire logic             mclk,                    // 100 MHz clock
    input  wire logic             reset_n,                 // async, low
    input  wire logic [7:0]       avs_address,             // byte address
    input  wire logic             avs_read,                // read request
    input  wire logic             avs_write,               // write request
    input  wire logic [31:0]      avs_writedata,           // write data
    input  wire logic [3:0]       avs_byteenable,          // byte lanes
    output var  logic [31:0]      avs_readdata,            // read data
    output var  logic             avs_waitrequest,         // stall master
    input  wire logic [N_CMP-1:0] raw_result,              // analog outs
    input  wire logic             t1_src_clk,              // timer clock
    input  wire logic [N_CMP-1:0] pin_route_select,        // pin mapped
    input  wire logic [N_CMP-1:0] pin_direction_bit,       // 1 = input
    output var  logic [N_CMP-1:0] comp_enable,             // power up
    output var  logic [N_CMP-1:0] input_separation_enable, // hysteresis
    output var  logic [N_CMP-1:0] pin_out,                 // pin level
    output var  logic [N_CMP-1:0] pin_oe,                  // pin driven
    output var  logic [N_CMP-1:0] timer_gate_src,          // gate source
    output var  logic             irq                      // level irq
);

    typedef struct packed {
        logic [N_CMP-1:0] on;
        logic [N_CMP-1:0] inv;
        logic [N_CMP-1:0] sep;
        logic [N_CMP-1:0] sync;
        logic [N_CMP-1:0] rise;
        logic [N_CMP-1:0] fall;
        logic [N_CMP-1:0] mask;
        logic [N_CMP-1:0] samp;
        logic [N_CMP-1:0] t1lat;
        logic [N_CMP-1:0] pin_out;
        logic [N_CMP-1:0] pin_oe;
        logic [N_CMP-1:0] gate;
        logic             t1_prev;
        logic             wreq;
        logic [31:0]      rdata;
        logic             irq;
    } cmp_top_state_t;

    cmp_top_state_t   st_q;
    cmp_top_state_t   st_d;

    logic [N_CMP:0]   synced;
    logic [N_CMP-1:0] raw_s;
    logic             t1_s;
    logic [N_CMP-1:0] level;
    logic [N_CMP-1:0] reported_result;
    logic [N_CMP-1:0] edge_event_flag;
    logic [N_CMP-1:0] clr;
    logic             req;
    logic             commit_wr;
    logic             lane0;
    wire  logic [N_CMP-1:0]    wr_first;
    wire  logic [N_CMP-1:0]    wr_second;
    wire  logic [N_CMP:0][7:0] rd_chain;

    generate
        if (N_CMP < 1 || N_CMP > cmp_pkg::MAX_CMP) begin : g_chk
            $error("cmp_output_ctrl: N_CMP must lie in 1..8");
        end
    endgenerate

    // raw results and the timer clock come from other domains
    cmp_sync2 #(
        .W    (N_CMP + 1)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     ({t1_src_clk, raw_result}),
        .dout    (synced)
    );

    assign raw_s = synced[N_CMP-1:0];
    assign t1_s  = synced[N_CMP];

    // polarity applied after the per-cycle latch
    assign level = st_q.samp ^ st_q.inv;

    // timer-synchronised copy replaces the live one when sync is set
    assign reported_result = (st_q.sync & st_q.t1lat)
                           | (~st_q.sync & level);

    cmp_edge_flag #(
        .W    (N_CMP)
    ) u_edge (
        .mclk    (mclk),
        .reset_n (reset_n),
        .level   (reported_result),
        .rise_en (st_q.rise),
        .fall_en (st_q.fall),
        .clear   (clr),
        .flag    (edge_event_flag)
    );

    assign req       = avs_read | avs_write;
    assign commit_wr = avs_write & ~st_q.wreq;
    assign lane0     = avs_byteenable[0];

    // write-one-to-clear of the event flags
    assign clr = (commit_wr && lane0
                  && avs_address == cmp_pkg::IRQ_STATUS_OFF)
               ? avs_writedata[N_CMP-1:0] : '0;

    // per-channel decode; each channel answers only its own pair
    assign rd_chain[0] = 8'h00;

    generate
        for (genvar g = 0; g < N_CMP; g++) begin : g_chan
            localparam logic [7:0] A_FIRST  = 8'(cmp_pkg::CTRL_FIRST_BASE
                + cmp_pkg::CHAN_STRIDE * g);
            localparam logic [7:0] A_SECOND = 8'(cmp_pkg::CTRL_SECOND_BASE
                + cmp_pkg::CHAN_STRIDE * g);
            wire logic       hit_first;
            wire logic       hit_second;
            wire logic [7:0] word_first;
            wire logic [7:0] word_second;

            assign hit_first     = (avs_address == A_FIRST);
            assign hit_second    = (avs_address == A_SECOND);
            assign wr_first[g]  = commit_wr & lane0 & hit_first;
            assign wr_second[g] = commit_wr & lane0 & hit_second;

            // unused bit positions read zero
            assign word_first =
                  ({8{st_q.on[g]}} & (8'h01 << cmp_pkg::CF_ON_BIT))
                | ({8{reported_result[g]}} & (8'h01 << cmp_pkg::CF_OUT_BIT))
                | ({8{st_q.inv[g]}} & (8'h01 << cmp_pkg::CF_INV_BIT))
                | ({8{st_q.sep[g]}} & (8'h01 << cmp_pkg::CF_SEP_BIT))
                | ({8{st_q.sync[g]}} & (8'h01 << cmp_pkg::CF_SYNC_BIT));
            assign word_second =
                  ({8{st_q.rise[g]}} & (8'h01 << cmp_pkg::CS_RISE_BIT))
                | ({8{st_q.fall[g]}} & (8'h01 << cmp_pkg::CS_FALL_BIT));

            assign rd_chain[g+1] = rd_chain[g]
                                 | (hit_first  ? word_first  : 8'h00)
                                 | (hit_second ? word_second : 8'h00);
        end
    endgenerate

    always_comb begin
        logic [7:0] wb;
        logic [7:0] rd;
        logic       t1_fall;
        wb       = avs_writedata[7:0];
        rd       = 8'h00;
        t1_fall  = st_q.t1_prev & ~t1_s;
        st_d     = st_q;

        // disabled comparator samples low, so it reads as its inv bit; latched every cycle
        st_d.samp    = raw_s & st_q.on;
        st_d.t1_prev = t1_s;
        if (t1_fall) begin
            st_d.t1lat = level;
        end

        // pin path bypasses the timer latch
        st_d.pin_out = level;
        st_d.pin_oe  = pin_route_select
                     & ~pin_direction_bit
                     & st_q.on;
        // software keeps sync set while this gates the timer
        st_d.gate    = reported_result;
        st_d.irq     = |(edge_event_flag & st_q.mask);

        // one wait cycle, then the answer; idle high
        if (req && st_q.wreq) begin
            st_d.wreq = 1'b0;
        end else begin
            st_d.wreq = 1'b1;
        end

        // strobes are one-hot by address, so channels never mix
        st_d.on   = (st_q.on & ~wr_first)
                  | (wr_first & {N_CMP{wb[cmp_pkg::CF_ON_BIT]}});
        st_d.inv  = (st_q.inv & ~wr_first)
                  | (wr_first & {N_CMP{wb[cmp_pkg::CF_INV_BIT]}});
        st_d.sep  = (st_q.sep & ~wr_first)
                  | (wr_first & {N_CMP{wb[cmp_pkg::CF_SEP_BIT]}});
        st_d.sync = (st_q.sync & ~wr_first)
                  | (wr_first & {N_CMP{wb[cmp_pkg::CF_SYNC_BIT]}});
        st_d.rise = (st_q.rise & ~wr_second)
                  | (wr_second & {N_CMP{wb[cmp_pkg::CS_RISE_BIT]}});
        st_d.fall = (st_q.fall & ~wr_second)
                  | (wr_second & {N_CMP{wb[cmp_pkg::CS_FALL_BIT]}});
        rd        = rd_chain[N_CMP];

        if (commit_wr && lane0 && avs_address == cmp_pkg::IRQ_MASK_OFF) begin
            st_d.mask = avs_writedata[N_CMP-1:0];
        end

        // shared registers; unmapped addresses read zero
        case (avs_address)
            cmp_pkg::ALL_RESULTS_OFF: begin
                rd[N_CMP-1:0] = reported_result;
            end
            cmp_pkg::IRQ_STATUS_OFF: begin
                rd[N_CMP-1:0] = edge_event_flag;
            end
            cmp_pkg::IRQ_MASK_OFF: begin
                rd[N_CMP-1:0] = st_q.mask;
            end
            default: begin
                rd = rd;
            end
        endcase

        // data are captured while the wait cycle is shown
        if (avs_read && st_q.wreq) begin
            st_d.rdata = {24'h00_0000, rd};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q.on      <= {N_CMP{cmp_pkg::ON_RESET}};
            st_q.inv     <= {N_CMP{cmp_pkg::INV_RESET}};
            st_q.sep     <= {N_CMP{cmp_pkg::SEP_RESET}};
            st_q.sync    <= {N_CMP{cmp_pkg::SYNC_RESET}};
            st_q.rise    <= {N_CMP{cmp_pkg::RISE_RESET}};
            st_q.fall    <= {N_CMP{cmp_pkg::FALL_RESET}};
            st_q.mask    <= {N_CMP{cmp_pkg::MASK_RESET}};
            st_q.samp    <= '0;
            st_q.t1lat   <= '0;
            st_q.pin_out <= '0;
            st_q.pin_oe  <= '0;
            st_q.gate    <= '0;
            st_q.t1_prev <= 1'b0;
            st_q.wreq    <= 1'b1;
            st_q.rdata   <= cmp_pkg::RDATA_RESET;
            st_q.irq     <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // the analog cores take enable and separation straight from flops
    assign comp_enable             = st_q.on;
    assign input_separation_enable = st_q.sep;
    assign pin_out                 = st_q.pin_out;
    assign pin_oe                  = st_q.pin_oe;
    assign timer_gate_src          = st_q.gate;
    assign avs_readdata            = st_q.rdata;
    assign avs_waitrequest         = st_q.wreq;
    assign irq                     = st_q.irq;

endmodule // cmp_output_ctrl

`default_nettype wire

// [cmp_output_ctrl_sva.sv]
// port assertions for the comparator output control block
`timescale 1ns/1ns
`default_nettype none
module cmp_output_ctrl_sva #(
    parameter int unsigned N_CMP = 8
) (
    input wire logic             mclk,                    // clock
    input wire logic             reset_n,                 // async reset
    input wire logic             avs_read,                // read req
    input wire logic             avs_write,               // write req
    input wire logic [31:0]      avs_readdata,            // read data
    input wire logic             avs_waitrequest,         // stall
    input wire logic [N_CMP-1:0] raw_result,              // core outs
    input wire logic             t1_src_clk,              // timer clock
    input wire logic [N_CMP-1:0] pin_route_select,        // routed
    input wire logic [N_CMP-1:0] pin_direction_bit,       // 1 = in
    input wire logic [N_CMP-1:0] comp_enable,             // powered
    input wire logic [N_CMP-1:0] input_separation_enable, // hysteresis
    input wire logic [N_CMP-1:0] pin_out,                 // pin level
    input wire logic [N_CMP-1:0] pin_oe,                  // pin driven
    input wire logic             irq                      // level irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic wr_done;
    assign wr_done = avs_write && !avs_waitrequest;
    sequence s_pins_still;
        $stable(pin_route_select) && $stable(pin_direction_bit)
            && $stable(comp_enable);
    endsequence
    chk_wait_once: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_req_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    chk_wait_cause: assert property (
        $fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    chk_pin_gate: assert property (
        s_pins_still [*2] |->
        pin_oe == (pin_route_select & ~pin_direction_bit & comp_enable))
        else $error("pin enable not route and output and on");
    chk_en_write: assert property (
        !$stable(comp_enable) |-> $past(wr_done))
        else $error("enable moved without a write");
    chk_sep_write: assert property (
        !$stable(input_separation_enable) |-> $past(wr_done))
        else $error("separation moved without a write");
    chk_rdata_top: assert property (
        avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_quiet_hold: assert property (
        (!avs_read && !avs_write && $stable(raw_result)
            && $stable(t1_src_clk)) [*8] |->
        $stable(pin_out) && $stable(irq))
        else $error("outputs moved with quiet inputs");
    cover property (irq);
    cover property (wr_done);
    cover property ($rose(pin_oe[0]));
endmodule // cmp_output_ctrl_sva
bind cmp_output_ctrl cmp_output_ctrl_sva #(.N_CMP(N_CMP)) i_chk (.mclk,
    .reset_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .raw_result, .t1_src_clk, .pin_route_select, .pin_direction_bit,
    .comp_enable,
    .input_separation_enable, .pin_out, .pin_oe, .irq);
`default_nettype wire

// [cmp_analog_model.sv]
// analog comparator cores and timer one source clock
`timescale 1ns/1ns
`default_nettype none
module cmp_analog_model #(
    parameter int unsigned N_CMP = 8
) (
    input  wire logic [N_CMP-1:0] comp_enable, // powered
    input  wire logic [N_CMP-1:0] vp_above,    // plus above minus
    input  wire logic             t1_run,      // timer clock on
    output var  logic [N_CMP-1:0] raw_result,  // core outputs
    output var  logic             t1_src_clk   // timer source clock
);
    // an unpowered core shows a wrong level so a missing gate shows up
    assign raw_result = (comp_enable & vp_above)
        | (~comp_enable & ~vp_above);
    initial begin
        t1_src_clk = 1'b0;
        forever begin
            #23;
            // stands still while not running
            if (t1_run)
                t1_src_clk = ~t1_src_clk;
        end
    end
endmodule // cmp_analog_model
`default_nettype wire

// [cmp_output_ctrl_tb.sv]
// self-checking bench for the comparator output control block
`timescale 1ns/1ns
`default_nettype none
module cmp_output_ctrl_tb;
    localparam logic [7:0] INV = 8'h3c;
    localparam logic [7:0] SEP = 8'h96;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rdv = 1'b0;
    logic        wrv = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  be = 4'hf;
    logic [31:0] rdat;
    logic        wreq;
    logic [7:0]  raw, en, sep, pout, poe, gate;
    logic [7:0]  above = 8'h00;
    logic [7:0]  route = 8'hff;
    logic [7:0]  dir = 8'h05;
    logic        t1clk, irq;
    logic        t1run = 1'b0;
    int          miscompares = 0;
    int          comparisons = 0;
    cmp_output_ctrl i_dut (.mclk(mclk), .reset_n(reset_n),
        .avs_address(adr), .avs_read(rdv), .avs_write(wrv),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .raw_result(raw), .t1_src_clk(t1clk),
        .pin_route_select(route), .pin_direction_bit(dir),
        .comp_enable(en), .input_separation_enable(sep), .pin_out(pout),
        .pin_oe(poe), .timer_gate_src(gate), .irq(irq));
    cmp_analog_model i_core (.comp_enable(en), .vp_above(above),
        .t1_run(t1run), .raw_result(raw), .t1_src_clk(t1clk));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        adr <= a;
        wdat <= {24'h0, d};
        wrv <= w;
        rdv <= !w;
        @(posedge mclk);
        // no cycle count assumed: only the watchdog ends a hung wait
        while (wreq !== 1'b0) begin
            @(posedge mclk);
        end
        q = rdat[7:0];
        wrv <= 1'b0;
        rdv <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    initial begin
        idle(6);
        reset_n <= 1'b1;
        idle(1);
        rd(8'h00, 8'h00);
        rd(8'h4c, 8'h00);
        above <= 8'ha5;
        for (int i = 0; i < 8; i++)
            wr(8'(8 * i), {1'b1, 2'b0, INV[i], 2'b0, SEP[i], 1'b0});
        idle(6);
        rd(8'h40, 8'h99);
        chk(en, 8'hff);
        chk(sep, SEP);
        chk(gate, 8'h99);
        for (int i = 4; i < 8; i++)
            wr(8'(8 * i), {3'b0, INV[i], 4'h0});
        idle(6);
        rd(8'h40, 8'h39);
        rd(8'h00, 8'hc0);
        rd(8'h10, 8'h92);
        chk(poe, 8'h0a);
        chk(pout & poe, 8'h08);
        route <= 8'h0e;
        dir <= 8'h00;
        idle(3);
        chk(poe, 8'h0e);
        wr(8'h04, 8'h80);
        wr(8'h48, 8'h01);
        wr(8'h44, 8'hff);
        above <= 8'ha4;
        idle(8);
        rd(8'h44, 8'h00);
        above <= 8'ha5;
        idle(8);
        rd(8'h44, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr(8'h48, 8'h00);
        idle(2);
        chk({7'h0, irq}, 8'h00);
        wr(8'h44, 8'h01);
        rd(8'h44, 8'h00);
        wr(8'h04, 8'h40);
        above <= 8'ha4;
        idle(8);
        rd(8'h44, 8'h01);
        wr(8'h08, 8'h81);
        t1run <= 1'b1;
        idle(20);
        t1run <= 1'b0;
        idle(8);
        chk({7'h0, gate[1]}, 8'h00);
        above <= 8'ha6;
        idle(8);
        chk({7'h0, gate[1]}, 8'h00);
        chk({7'h0, pout[1]}, 8'h01);
        t1run <= 1'b1;
        idle(20);
        t1run <= 1'b0;
        idle(8);
        chk({7'h0, gate[1]}, 8'h01);
        be <= 4'h0;
        wr(8'h48, 8'hff);
        be <= 4'hf;
        rd(8'h48, 8'h00);
        complete_run();
    end
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
endmodule // cmp_output_ctrl_tb
`default_nettype wire
